/* shared/prc_pkg.sv */
// Summary of operation
// - Unknown parameter number is rejected with code 00h.
// - Write to a read-only value is rejected with code 01h.
// - Write value below lower or above upper limit gives code 02h.
// - Nonexistent subindex for the parameter gives code 03h.
// - Subindex applied to a non-array parameter gives code 04h.
// - Write value type differing from declared type gives code 05h.
// - Clear-only parameter accepts zero only; nonzero write gives 06h.
// - Write to a fixed description element gives code 07h.
// - Description asked but parameter has none gives code 09h.
// - Change without modify rights gives code 0Bh.
// - Text array asked but parameter has none gives code 0Fh.
// - Applying mapping while mapping disabled gives code 11h.
// - User unit enable written outside inhibited or ready states gives 11h.
// - Position limit writes in operation or switching off give 11h.
// - Switch on or operation command with main power off gives 11h.
// - Pole detection mode selected while servo on gives 11h.
// - Leaving pole detection mode before completion gives 11h.
// - Store command while user unit setting enabled gives 11h.
// - Store or restore outside inhibited or ready states gives 11h.
// - Change to parameter 922 outside inhibited or ready states gives 11h.
// - In-limit value not among permitted discrete values gives 14h.
package prc_pkg;

   // Error codes returned to the requester
   localparam logic [7:0] ERR_NO_PARAM      = 8'h00;
   localparam logic [7:0] ERR_READ_ONLY     = 8'h01;
   localparam logic [7:0] ERR_LIMIT         = 8'h02;
   localparam logic [7:0] ERR_SUBINDEX      = 8'h03;
   localparam logic [7:0] ERR_NO_ARRAY      = 8'h04;
   localparam logic [7:0] ERR_DATA_TYPE     = 8'h05;
   localparam logic [7:0] ERR_RESET_ONLY    = 8'h06;
   localparam logic [7:0] ERR_DESC_FIXED    = 8'h07;
   localparam logic [7:0] ERR_NO_DESC       = 8'h09;
   localparam logic [7:0] ERR_NO_PRIORITY   = 8'h0B;
   localparam logic [7:0] ERR_NO_TEXT       = 8'h0F;
   localparam logic [7:0] ERR_OP_MODE       = 8'h11;
   localparam logic [7:0] ERR_VALUE         = 8'h14;
   localparam logic [7:0] ERR_NONE_CODE     = 8'hFF;

   // Parameter numbers with state-dependent access, and the store/restore command and clear values
   localparam logic [15:0] PNU_RESTORE      = 16'h03D0;
   localparam logic [15:0] PNU_STORE        = 16'h03D1;
   localparam logic [15:0] PNU_TELEGRAM     = 16'h039A;
   localparam logic [15:0] IDX_USER_UNIT    = 16'h2300;
   localparam logic [31:0] CMD_VALUE_ONE    = 32'h0000_0001;
   localparam logic [31:0] VALUE_ZERO       = 32'h0000_0000;

   // Drive machine states
   typedef enum logic [2:0] {
      state_switch_on_inhibited = 3'b000,
      state_ready_to_switch_on  = 3'b001,
      state_switched_on         = 3'b010,
      state_operation_enabled   = 3'b011,
      state_switching_off       = 3'b100,
      substate_ramp_stop        = 3'b101,
      substate_quick_stop       = 3'b110,
      state_fault               = 3'b111
   } prc_mstate_e;

   // What the request touches
   typedef enum logic [1:0] {
      ATTR_VALUE = 2'b00,
      ATTR_DESC  = 2'b01,
      ATTR_TEXT  = 2'b10
   } prc_attr_e;

   // Request from the fieldbus side
   typedef struct packed {
      logic        write;
      prc_attr_e   attr;
      logic [15:0] pnu;
      logic        has_subidx;
      logic [7:0]  subidx;
      logic [31:0] value;
      logic [3:0]  value_type;
      logic        desc_fixed_elem;
      logic        map_apply;
      logic        cmd_power_on;
      logic        mode_to_pole;
      logic        mode_from_pole;
      logic        pos_limit_obj;
   } prc_req_s;

   // Attributes of the addressed parameter, from the dictionary
   typedef struct packed {
      logic        exists;
      logic        read_only;
      logic        is_array;
      logic [7:0]  num_elems;
      logic [3:0]  dtype;
      logic        signed_val;
      logic [31:0] low_limit;
      logic [31:0] high_limit;
      logic        clear_only;
      logic        has_desc;
      logic        has_text;
      logic        discrete;
      logic        value_allowed;
   } prc_attr_s;

   // Drive status seen by the checker
   typedef struct packed {
      prc_mstate_e mstate;
      logic        write_rights;
      logic        map_enabled;
      logic        main_power_on;
      logic        servo_on;
      logic        pole_done;
      logic        user_unit_en;
   } prc_drv_s;

   // Answer to the requester
   typedef struct packed {
      logic       done;
      logic       error;
      logic [7:0] code;
      logic       exec;
   } prc_rsp_s;

endpackage

/* rtl/prc_check.sv */
`timescale 1ns/100ps
// Checks one acyclic parameter request per valid pulse and answers one
// cycle later with a single verdict: an error code or permission to act.
module prc_check (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic             req_valid,
   input  wire prc_pkg::prc_req_s  req,
   input  wire prc_pkg::prc_attr_s attr,
   input  wire prc_pkg::prc_drv_s  drv,
   output prc_pkg::prc_rsp_s       rsp
);

   typedef struct packed {
      prc_pkg::prc_rsp_s rsp;
   } prc_state_s;

   prc_state_s state_reg;
   prc_state_s state_next;

   logic       idle_state;
   logic       run_state;
   logic       below_low;
   logic       above_high;
   logic       fail;
   logic [7:0] code;

   // Machine state groupings
   always_comb begin
      idle_state = (drv.mstate == prc_pkg::state_switch_on_inhibited) ||
                   (drv.mstate == prc_pkg::state_ready_to_switch_on);
      run_state  = (drv.mstate == prc_pkg::state_operation_enabled) ||
                   (drv.mstate == prc_pkg::state_switching_off) ||
                   (drv.mstate == prc_pkg::substate_ramp_stop) ||
                   (drv.mstate == prc_pkg::substate_quick_stop);
   end

   // Limit compare honours the parameter's signedness
   always_comb begin
      if (attr.signed_val) begin
         below_low  = $signed(req.value) < $signed(attr.low_limit);
         above_high = $signed(req.value) > $signed(attr.high_limit);
      end else begin
         below_low  = req.value < attr.low_limit;
         above_high = req.value > attr.high_limit;
      end
   end

   // Priority chain: addressing faults first, then the unchangeable description
   // element, rights and read-only, then the state-dependent refusals, then value checks. Only one code leaves.
   always_comb begin
      fail = 1'b1;
      code = prc_pkg::ERR_NONE_CODE;
      if (!attr.exists) begin
         code = prc_pkg::ERR_NO_PARAM;
      end else if (req.has_subidx && !attr.is_array) begin
         code = prc_pkg::ERR_NO_ARRAY;
      end else if (req.has_subidx && req.subidx >= attr.num_elems) begin
         code = prc_pkg::ERR_SUBINDEX;
      end else if (req.attr == prc_pkg::ATTR_DESC && !attr.has_desc) begin
         code = prc_pkg::ERR_NO_DESC;
      end else if (req.attr == prc_pkg::ATTR_TEXT && !attr.has_text) begin
         code = prc_pkg::ERR_NO_TEXT;
      end else if (req.write && req.attr == prc_pkg::ATTR_DESC &&
                   req.desc_fixed_elem) begin
         code = prc_pkg::ERR_DESC_FIXED;
      end else if (req.write && !drv.write_rights) begin
         code = prc_pkg::ERR_NO_PRIORITY;
      end else if (req.write && attr.read_only) begin
         code = prc_pkg::ERR_READ_ONLY;
      end else if (req.map_apply && !drv.map_enabled) begin
         code = prc_pkg::ERR_OP_MODE;
      end else if (req.write && req.pnu == prc_pkg::IDX_USER_UNIT &&
                   !idle_state) begin
         code = prc_pkg::ERR_OP_MODE;
      end else if (req.write && req.pos_limit_obj && run_state) begin
         code = prc_pkg::ERR_OP_MODE;
      end else if (req.cmd_power_on && !drv.main_power_on) begin
         code = prc_pkg::ERR_OP_MODE;
      end else if (req.mode_to_pole && drv.servo_on) begin
         code = prc_pkg::ERR_OP_MODE;
      end else if (req.mode_from_pole && !drv.pole_done) begin
         code = prc_pkg::ERR_OP_MODE;
      end else if (req.write && req.pnu == prc_pkg::PNU_STORE &&
                   req.value == prc_pkg::CMD_VALUE_ONE &&
                   drv.user_unit_en) begin
         code = prc_pkg::ERR_OP_MODE;
      end else if (req.write && (req.pnu == prc_pkg::PNU_STORE ||
                   req.pnu == prc_pkg::PNU_RESTORE) &&
                   req.value == prc_pkg::CMD_VALUE_ONE && !idle_state) begin
         code = prc_pkg::ERR_OP_MODE;
      end else if (req.write && req.pnu == prc_pkg::PNU_TELEGRAM &&
                   !idle_state) begin
         code = prc_pkg::ERR_OP_MODE;
      end else if (req.write && req.value_type != attr.dtype) begin
         code = prc_pkg::ERR_DATA_TYPE;
      end else if (req.write && attr.clear_only &&
                   req.value != prc_pkg::VALUE_ZERO) begin
         code = prc_pkg::ERR_RESET_ONLY;
      end else if (req.write && (below_low || above_high)) begin
         code = prc_pkg::ERR_LIMIT;
      end else if (req.write && attr.discrete && !attr.value_allowed) begin
         code = prc_pkg::ERR_VALUE;
      end else begin
         fail = 1'b0;
      end
   end

   // Next-state: answer pulses for one cycle after each request
   always_comb begin
      state_next          = state_reg;
      state_next.rsp.done = req_valid;
      if (req_valid) begin
         state_next.rsp.error = fail;
         state_next.rsp.code  = fail ? code : prc_pkg::ERR_NONE_CODE;
         state_next.rsp.exec  = !fail;
      end else begin
         state_next.rsp.exec  = 1'b0;
      end
   end

   // Verdict register; reset leaves the no-error code showing
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
         state_reg.rsp.code <= prc_pkg::ERR_NONE_CODE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rsp = state_reg.rsp;

   // Checks sample the verdict one edge after the strobe, where it stands;
   // reset disables them so the flush of the answer flop is not judged.

   // Accept and refuse never leave together
   chk_exec_error_excl: assert property (
      @(posedge clock) disable iff (!reset_n)
      rsp.done |-> (rsp.exec != rsp.error))
      else $error("exec and error clash");

   // The no-error code shows exactly when nothing failed
   chk_code_matches: assert property (
      @(posedge clock) disable iff (!reset_n)
      rsp.done |-> rsp.error == (rsp.code != 8'hFF))
      else $error("code and error flag disagree");

   // Permission to act only comes with an answer
   chk_exec_needs_done: assert property (
      @(posedge clock) disable iff (!reset_n)
      rsp.exec |-> rsp.done)
      else $error("exec without answer");

   // One answer, one cycle after its request
   chk_done_pulse: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid |=> rsp.done ##1 (rsp.done == $past(req_valid)))
      else $error("answer not one cycle after request");

   // No strobe, no answer
   chk_idle_quiet: assert property (
      @(posedge clock) disable iff (!reset_n)
      !req_valid |=> !rsp.done && !rsp.exec)
      else $error("answer without request");

   // Verdict holds until the next request is taken
   chk_verdict_hold: assert property (
      @(posedge clock) disable iff (!reset_n)
      !req_valid |=> $stable(rsp.code) && $stable(rsp.error))
      else $error("verdict moved without request");

   // A plain value read of a known parameter is always performed
   chk_clean_accept: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && attr.exists && !req.write && !req.has_subidx &&
      req.attr == prc_pkg::ATTR_VALUE && !req.map_apply &&
      !req.cmd_power_on && !req.mode_to_pole && !req.mode_from_pole
      |=> rsp.exec && rsp.code == 8'hFF)
      else $error("clean read refused");

   // Unknown parameter outranks every other cause
   chk_missing_param: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && !attr.exists |=> rsp.error && rsp.code == 8'h00)
      else $error("missing parameter not 00h");

   // Read-only value with nothing else wrong
   chk_read_only: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && attr.exists && req.write && attr.read_only &&
      !req.has_subidx && req.attr == prc_pkg::ATTR_VALUE && drv.write_rights
      |=> rsp.code == 8'h01)
      else $error("read-only write not 01h");

   // Unsigned value above the upper limit is never performed
   chk_limit_high: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && req.write && !attr.signed_val &&
      req.value > attr.high_limit |=> rsp.error && !rsp.exec)
      else $error("value above limit accepted");

   // Signed value below the lower limit is never performed
   chk_limit_low: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && req.write && attr.signed_val &&
      $signed(req.value) < $signed(attr.low_limit)
      |=> rsp.error && !rsp.exec)
      else $error("value below limit accepted");

   // Subindex past the last element of an array
   chk_bad_subidx: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && attr.exists && attr.is_array && req.has_subidx &&
      req.subidx >= attr.num_elems |=> rsp.code == 8'h03)
      else $error("bad subindex not 03h");

   // Subindex on a plain parameter
   chk_no_array: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && attr.exists && req.has_subidx && !attr.is_array
      |=> rsp.code == 8'h04)
      else $error("no array not 04h");

   // Wrong data type on a write is never performed
   chk_data_type: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && req.write && req.value_type != attr.dtype
      |=> rsp.error && !rsp.exec)
      else $error("type mismatch accepted");

   // Clear-only parameter refuses anything but zero
   chk_clear_only: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && req.write && attr.clear_only &&
      req.value != 32'h0000_0000 |=> rsp.error && !rsp.exec)
      else $error("nonzero clear accepted");

   // Fixed description element with nothing else wrong
   chk_desc_fixed: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && attr.exists && !req.has_subidx && req.write &&
      req.attr == prc_pkg::ATTR_DESC && attr.has_desc &&
      req.desc_fixed_elem |=> rsp.code == 8'h07)
      else $error("fixed description not 07h");

   // Description asked where none exists
   chk_no_desc: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && attr.exists && !req.has_subidx &&
      req.attr == prc_pkg::ATTR_DESC && !attr.has_desc
      |=> rsp.code == 8'h09)
      else $error("missing description not 09h");

   // Write without rights, addressing otherwise sound
   chk_rights: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && attr.exists && req.write && !drv.write_rights &&
      !req.has_subidx && req.attr == prc_pkg::ATTR_VALUE
      |=> rsp.code == 8'h0B)
      else $error("rights not 0Bh");

   // Text array asked where none exists
   chk_no_text: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && attr.exists && !req.has_subidx &&
      req.attr == prc_pkg::ATTR_TEXT && !attr.has_text
      |=> rsp.code == 8'h0F)
      else $error("missing text array not 0Fh");

   // Mapping applied while disabled, on a plain read
   chk_map_enable: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && attr.exists && !req.has_subidx && !req.write &&
      req.attr == prc_pkg::ATTR_VALUE && req.map_apply &&
      !drv.map_enabled |=> rsp.code == 8'h11)
      else $error("mapping refusal not 11h");

   // User unit enable only moves in the two idle states
   chk_user_unit: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && req.write && req.pnu == 16'h2300 &&
      drv.mstate > prc_pkg::state_ready_to_switch_on |=> !rsp.exec)
      else $error("user unit change accepted in run");

   // Position limits frozen while running or stopping
   chk_pos_limit: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && req.write && req.pos_limit_obj &&
      drv.mstate >= prc_pkg::state_operation_enabled &&
      drv.mstate <= prc_pkg::substate_quick_stop |=> !rsp.exec)
      else $error("position limit changed in run");

   // No switching on without main power
   chk_main_power: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && req.cmd_power_on && !drv.main_power_on |=> !rsp.exec)
      else $error("power-on accepted with mains off");

   // Power-on command with mains off, nothing else wrong, answers 11h
   chk_power_code: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && attr.exists && !req.has_subidx && !req.write &&
      req.attr == prc_pkg::ATTR_VALUE && !req.map_apply &&
      req.cmd_power_on && !drv.main_power_on |=> rsp.code == 8'h11)
      else $error("power refusal not 11h");

   // Pole detection only from servo off
   chk_pole_servo: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && req.mode_to_pole && drv.servo_on |=> !rsp.exec)
      else $error("pole mode accepted with servo on");

   // Pole detection cannot be left before it completes
   chk_pole_leave: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && req.mode_from_pole && !drv.pole_done |=> !rsp.exec)
      else $error("pole mode left before completion");

   // Store refused while user units are enabled or the drive is busy
   chk_store_state: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && req.write && req.pnu == 16'h03D1 &&
      req.value == 32'h0000_0001 && (!idle_state || drv.user_unit_en)
      |=> rsp.error)
      else $error("store accepted wrongly");

   // Restore only in the two idle states
   chk_restore_state: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && req.write && req.pnu == 16'h03D0 &&
      req.value == 32'h0000_0001 &&
      drv.mstate > prc_pkg::state_ready_to_switch_on |=> rsp.error)
      else $error("restore accepted in run");

   // Telegram selection only in the two idle states
   chk_pnu922_state: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && req.write && req.pnu == 16'h039A && !idle_state
      |=> !rsp.exec)
      else $error("922 change accepted in run");

   // Discrete parameter refuses values off its list
   chk_discrete: assert property (
      @(posedge clock) disable iff (!reset_n)
      req_valid && req.write && attr.discrete && !attr.value_allowed
      |=> rsp.error && !rsp.exec)
      else $error("disallowed discrete value accepted");

endmodule

/* test/prc_host.sv */
`timescale 1ns/100ps
// Fieldbus controller side: one request per call, strobe for one edge
module prc_host (
   input  wire logic         clock,
   output logic              req_valid,
   output prc_pkg::prc_req_s req
);
   initial begin
      req_valid = 1'b0;
      req = '0;
   end
   // Fields inverted after the strobe, so stale data is never trusted
   task automatic send(input prc_pkg::prc_req_s r);
      @(negedge clock);
      req_valid = 1'b1;
      req = r;
      @(negedge clock);
      req_valid = 1'b0;
      req = ~r;
   endtask
endmodule

/* test/tb.sv */
`timescale 1ns/100ps
module tb;
   localparam logic [7:0] OK  = prc_pkg::ERR_NONE_CODE;
   localparam logic [7:0] OPM = prc_pkg::ERR_OP_MODE;
   logic               clock;
   logic               reset_n;
   logic               req_valid;
   prc_pkg::prc_req_s  req;
   prc_pkg::prc_req_s  r;
   prc_pkg::prc_attr_s a;
   prc_pkg::prc_drv_s  d;
   prc_pkg::prc_rsp_s  rsp;
   int                 miscompares;
   int                 n_tests;
   // Free running 40 MHz clock
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   prc_host host (.clock(clock), .req_valid(req_valid), .req(req));
   prc_check dut (.clock(clock), .reset_n(reset_n), .req_valid(req_valid),
                  .req(req), .attr(a), .drv(d), .rsp(rsp));
   // One place that judges and ends the run
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   // A legal, in-limit write in an idle drive: nothing should object
   task automatic base();
      r = '0;
      r.write = 1'b1;
      r.pnu = 16'h0064;
      r.value = 32'h0000_0005;
      r.value_type = 4'h3;
      a = '0;
      a.exists = 1'b1;
      a.dtype = 4'h3;
      a.high_limit = 32'h0000_03E8;
      a.has_desc = 1'b1;
      a.has_text = 1'b1;
      d = '0;
      d.mstate = prc_pkg::state_switch_on_inhibited;
      d.write_rights = 1'b1;
      d.map_enabled = 1'b1;
      d.main_power_on = 1'b1;
      d.pole_done = 1'b1;
   endtask
   // Answer stands at the negedge that ends the strobe; verdict then holds
   task automatic run(input logic [7:0] exp, input string nm);
      logic p;
      p = (exp === OK);
      host.send(r);
      cmp(rsp.done === 1'b1 && rsp.code === exp && rsp.error === !p
          && rsp.exec === p, nm);
      @(negedge clock);
      cmp(rsp.done === 1'b0 && rsp.exec === 1'b0 && rsp.code === exp
          && rsp.error === !p, nm);
      $display("test %s done", nm);
      base();
   endtask
   // Tests need about 96 cycles; a wide margin before calling it hung
   initial begin
      repeat (2000) @(posedge clock);
      miscompares++;
      complete_run();
   end
   initial begin
      reset_n = 1'b0;
      base();
      repeat (3) @(negedge clock);
      cmp(rsp.done === 1'b0 && rsp.exec === 1'b0 && rsp.code === OK, "rst");
      reset_n = 1'b1;
      run(OK, "clean");
      r.write = 1'b0;
      run(OK, "read");
      a.exists = 1'b0;
      a.read_only = 1'b1;
      run(8'h00, "nopar");
      a.read_only = 1'b1;
      r.value = 32'h0000_07D0;
      run(8'h01, "ro");
      r.value = 32'h0000_03E9;
      run(8'h02, "high");
      a.signed_val = 1'b1;
      a.low_limit = 32'hFFFF_FFF6;
      r.value = 32'hFFFF_FFF0;
      run(8'h02, "low");
      a.is_array = 1'b1;
      a.num_elems = 8'h04;
      r.has_subidx = 1'b1;
      r.subidx = 8'h04;
      run(8'h03, "subidx");
      r.has_subidx = 1'b1;
      run(8'h04, "noarr");
      r.value_type = 4'h2;
      run(8'h05, "dtype");
      a.clear_only = 1'b1;
      run(8'h06, "clr");
      a.clear_only = 1'b1;
      r.value = 32'h0000_0000;
      run(OK, "clr0");
      r.attr = prc_pkg::ATTR_DESC;
      r.desc_fixed_elem = 1'b1;
      run(8'h07, "descfix");
      r.write = 1'b0;
      r.attr = prc_pkg::ATTR_DESC;
      a.has_desc = 1'b0;
      run(8'h09, "nodesc");
      d.write_rights = 1'b0;
      run(8'h0B, "rights");
      r.write = 1'b0;
      r.attr = prc_pkg::ATTR_TEXT;
      a.has_text = 1'b0;
      run(8'h0F, "notext");
      r.write = 1'b0;
      r.map_apply = 1'b1;
      d.map_enabled = 1'b0;
      run(OPM, "map");
      r.pnu = prc_pkg::IDX_USER_UNIT;
      d.mstate = prc_pkg::state_switched_on;
      run(OPM, "uu");
      r.pnu = prc_pkg::IDX_USER_UNIT;
      d.mstate = prc_pkg::state_ready_to_switch_on;
      run(OK, "uuok");
      for (int s = 3; s < 7; s++) begin
         r.pos_limit_obj = 1'b1;
         d.mstate = prc_pkg::prc_mstate_e'(s[2:0]);
         run(OPM, "poslim");
      end
      r.pos_limit_obj = 1'b1;
      d.mstate = prc_pkg::state_switched_on;
      run(OK, "posok");
      r.write = 1'b0;
      r.cmd_power_on = 1'b1;
      d.main_power_on = 1'b0;
      run(OPM, "power");
      r.mode_to_pole = 1'b1;
      d.servo_on = 1'b1;
      run(OPM, "pole");
      r.mode_from_pole = 1'b1;
      d.pole_done = 1'b0;
      run(OPM, "leave");
      r.pnu = prc_pkg::PNU_STORE;
      r.value = prc_pkg::CMD_VALUE_ONE;
      d.user_unit_en = 1'b1;
      run(OPM, "store");
      r.pnu = prc_pkg::PNU_STORE;
      r.value = prc_pkg::CMD_VALUE_ONE;
      run(OK, "store0");
      r.pnu = prc_pkg::PNU_RESTORE;
      r.value = prc_pkg::CMD_VALUE_ONE;
      d.mstate = prc_pkg::state_switched_on;
      run(OPM, "restore");
      r.pnu = prc_pkg::PNU_TELEGRAM;
      d.mstate = prc_pkg::state_operation_enabled;
      run(OPM, "p922");
      a.discrete = 1'b1;
      run(8'h14, "discr");
      complete_run();
   end
endmodule
